// ### adc_source.sv
// Behavioural converter model feeding the sample port of the register bank
`timescale 1ns/10ps
`default_nettype none
module adc_source (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic sample_tick,
    input wire logic adc_chan_sel,
    input wire logic [7:0] ch1_level,
    input wire logic [7:0] ch2_level,
    output logic [7:0] adc_sample
);
    logic [7:0] noise; // Changes every cycle so a stale read never looks right

    // Free-running scrambler for the cycles outside a conversion result
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            noise <= 8'hA5;
        end else begin
            noise <= noise + 8'h5B;
        end
    end

    // Result only valid in the tick cycle; otherwise junk, as a real converter bus would be
    always_comb begin
        if (sample_tick) begin
            adc_sample = adc_chan_sel ? ch2_level : ch1_level;
        end else begin
            adc_sample = ~noise;
        end
    end
endmodule : adc_source
`default_nettype wire

// ### load_current_ctrl_regs.sv
// Register bank for converter samples and per-channel sink current selection
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Sample at 100 kHz, channels alternate, 50 kHz each
// - Raw pair: channel 2 high byte, channel 1 low
// - Decimated pair, rate from setting, read-only
// - Low idle, nonzero sample below threshold: low current code
// - Low idle, above threshold: high current code
// - High idle, nonzero sample: high current code
// - Threshold writes clamp to 0x01..0xFE
// - Threshold is 8-bit field, resets to 0x1E
// - Low code 6-bit field, resets to 0x1E
// - Low code write of zero stores one
// - Control resets to zero, low idle mode
// - High code 8-bit, write of zero stores one
// - Per-channel enables bits 14/15, cleared at reset
module load_current_ctrl_regs #(
    parameter int RATE_W = 2
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire load_regs_pkg::reg_req_t reg_req,
    output logic [load_regs_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [load_regs_pkg::SAMPLE_W-1:0] adc_sample,
    output logic adc_chan_sel,
    output logic sample_tick,
    input wire logic [RATE_W-1:0] decimation_rate_sel,
    output load_regs_pkg::sink_out_t ch1_sink_pin,
    output load_regs_pkg::sink_out_t ch2_sink_pin
);
    import load_regs_pkg::*;

    // Whole register state of the bank
    typedef struct packed {
        logic [TICK_W-1:0] tick_cnt;
        logic chan;
        logic [SAMPLE_W-1:0] ch1_raw_sample;
        logic [SAMPLE_W-1:0] ch2_raw_sample;
        logic load_idle_mode;
        logic [7:0] rising_threshold;
        logic [LOW_W-1:0] load_low_current;
        logic [7:0] load_high_current;
        logic ch1_load_enable;
        logic ch2_load_enable;
        logic [DATA_W-1:0] rdata;
    } bank_state_t;

    bank_state_t cur; // Registered state
    bank_state_t next_cur; // Value for the next edge
    logic tick; // One-cycle strobe: converter result is ready
    logic [SAMPLE_W-1:0] ch1_decimated_sample; // Channel 1 decimator output
    logic [SAMPLE_W-1:0] ch2_decimated_sample; // Channel 2 decimator output
    logic [7:0] wr_thr; // Write data for the threshold, before clamping
    logic [DATA_W-1:0] read_word; // Word selected for a read

    // Converter result strobe at the end of each 100-cycle slot
    assign tick = (cur.tick_cnt == TICK_LAST);

    // Read data selection; unmapped addresses read as zero
    always_comb begin
        read_word = '0;
        case (reg_req.addr)
            ADDR_RAW: begin
                read_word = {cur.ch2_raw_sample, cur.ch1_raw_sample};
            end
            ADDR_DEC: begin
                read_word = {ch2_decimated_sample, ch1_decimated_sample};
            end
            ADDR_CTRL: begin
                read_word[IDLE_MODE_BIT] = cur.load_idle_mode;
            end
            ADDR_THR: begin
                read_word[7:0] = cur.rising_threshold;
            end
            ADDR_LOW: begin
                read_word[LOW_W-1:0] = cur.load_low_current;
            end
            ADDR_HIGH: begin
                read_word[7:0] = cur.load_high_current;
            end
            ADDR_EN: begin
                read_word[EN1_BIT] = cur.ch1_load_enable;
                read_word[EN2_BIT] = cur.ch2_load_enable;
            end
            default: begin
                read_word = '0; // Unmapped: quiet zero, no error path exists
            end
        endcase
    end

    // Next-state logic: sampling pace, register writes, read capture
    always_comb begin
        next_cur = cur;
        wr_thr = reg_req.wdata[7:0];

        // Pace the converter; both channels share it, so each sees half the rate
        if (tick) begin
            next_cur.tick_cnt = '0;
            next_cur.chan = ~cur.chan;
            if (cur.chan) begin
                next_cur.ch2_raw_sample = adc_sample;
            end else begin
                next_cur.ch1_raw_sample = adc_sample;
            end
        end else begin
            next_cur.tick_cnt = cur.tick_cnt + 1'b1;
        end

        // Register writes; sample registers and reserved bits ignore them
        if (reg_req.wr) begin
            case (reg_req.addr)
                ADDR_CTRL: begin
                    next_cur.load_idle_mode = reg_req.wdata[IDLE_MODE_BIT];
                end
                ADDR_THR: begin
                    if (wr_thr < THR_MIN) begin
                        next_cur.rising_threshold = THR_MIN;
                    end else if (wr_thr > THR_MAX) begin
                        next_cur.rising_threshold = THR_MAX;
                    end else begin
                        next_cur.rising_threshold = wr_thr;
                    end
                end
                ADDR_LOW: begin
                    next_cur.load_low_current =
                        LOW_W'(at_least_one({2'b00, reg_req.wdata[LOW_W-1:0]}));
                end
                ADDR_HIGH: begin
                    next_cur.load_high_current = at_least_one(reg_req.wdata[7:0]);
                end
                ADDR_EN: begin
                    next_cur.ch1_load_enable = reg_req.wdata[EN1_BIT];
                    next_cur.ch2_load_enable = reg_req.wdata[EN2_BIT];
                end
                default: begin
                    next_cur.rdata = cur.rdata; // Read-only or unmapped: no effect
                end
            endcase
        end

        // Read data is held until the next read
        if (reg_req.rd) begin
            next_cur.rdata = read_word;
        end
    end

    // State register; every field takes its documented reset value
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '{
                tick_cnt: '0,
                chan: 1'b0,
                ch1_raw_sample: '0,
                ch2_raw_sample: '0,
                load_idle_mode: IDLE_MODE_RST,
                rising_threshold: THR_RST,
                load_low_current: LOW_RST,
                load_high_current: HIGH_RST,
                ch1_load_enable: 1'b0,
                ch2_load_enable: 1'b0,
                rdata: '0
            };
        end else begin
            cur <= next_cur;
        end
    end

    assign reg_rdata = cur.rdata;
    assign adc_chan_sel = cur.chan;
    assign sample_tick = tick;

    // Channel 1 decimator
    sample_decimator #(
        .DW(SAMPLE_W),
        .RATE_W(RATE_W)
    ) u_dec1 (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .sample_tick(tick && !cur.chan),
        .sample(adc_sample),
        .rate_sel(decimation_rate_sel),
        .decimated(ch1_decimated_sample)
    );

    // Channel 2 decimator
    sample_decimator #(
        .DW(SAMPLE_W),
        .RATE_W(RATE_W)
    ) u_dec2 (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .sample_tick(tick && cur.chan),
        .sample(adc_sample),
        .rate_sel(decimation_rate_sel),
        .decimated(ch2_decimated_sample)
    );

    // Channel 1 sink; acts on the stored sample, so it follows the 50 kHz refresh
    sink_code_select u_sink1 (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .enable(cur.ch1_load_enable),
        .idle_mode(cur.load_idle_mode),
        .sample(cur.ch1_raw_sample),
        .rising_threshold(cur.rising_threshold),
        .low_code(cur.load_low_current),
        .high_code(cur.load_high_current),
        .sink(ch1_sink_pin)
    );

    // Channel 2 sink
    sink_code_select u_sink2 (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .enable(cur.ch2_load_enable),
        .idle_mode(cur.load_idle_mode),
        .sample(cur.ch2_raw_sample),
        .rising_threshold(cur.rising_threshold),
        .low_code(cur.load_low_current),
        .high_code(cur.load_high_current),
        .sink(ch2_sink_pin)
    );

    // Write steps used by the clamp checks
    sequence s_thr_write(logic [7:0] v);
        reg_req.wr && reg_req.addr == ADDR_THR && reg_req.wdata[7:0] == v;
    endsequence

    sequence s_code_write(logic [ADDR_W-1:0] a);
        reg_req.wr && reg_req.addr == a && reg_req.wdata[7:0] == 8'h00;
    endsequence

    // Pacing: one strobe per slot, channels take turns
    AST_TICK_PERIOD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        tick |=> (!tick)[*8] ##91 !tick ##1 tick) else $error("sample strobe not every 100 cycles");

    AST_CH1_REFRESH: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (tick && !cur.chan) |-> ##200 (tick && !cur.chan)) else $error("channel 1 not refreshed at half rate");

    AST_CHAN_TOGGLE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        tick |=> adc_chan_sel != $past(adc_chan_sel)) else $error("channel select did not alternate");

    // A strobe fills only the field of the converted channel
    AST_CH1_CAPTURE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (tick && !cur.chan)
        |=> cur.ch1_raw_sample == $past(adc_sample)) else $error("channel 1 sample not stored");

    AST_CH2_CAPTURE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (tick && cur.chan)
        |=> cur.ch2_raw_sample == $past(adc_sample)) else $error("channel 2 sample not stored");

    AST_RAW_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !tick |=> ($stable(cur.ch1_raw_sample) && $stable(cur.ch2_raw_sample))) else $error("raw sample moved");

    // Read port: data shows the registers at the taking edge
    // A write in the same cycle is not yet visible to the read
    AST_RAW_READ: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (reg_req.rd && reg_req.addr == ADDR_RAW)
        |=> reg_rdata == {$past(cur.ch2_raw_sample), $past(cur.ch1_raw_sample)}) else $error("raw pair read wrong");

    AST_DEC_READ: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (reg_req.rd && reg_req.addr == ADDR_DEC)
        |=> reg_rdata == {$past(ch2_decimated_sample), $past(ch1_decimated_sample)})
        else $error("decimated pair read wrong");

    // Clamps keep every code in its legal range
    AST_THR_LOW_CLAMP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_thr_write(8'h00) |=> cur.rising_threshold == THR_MIN) else $error("threshold zero not clamped");

    AST_THR_HIGH_CLAMP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_thr_write(8'hFF) |=> cur.rising_threshold == THR_MAX) else $error("threshold 0xFF not clamped");

    AST_THR_RANGE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        cur.rising_threshold >= THR_MIN && cur.rising_threshold <= THR_MAX) else $error("threshold out of range");

    AST_LOW_MIN: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (reg_req.wr && reg_req.addr == ADDR_LOW && reg_req.wdata[LOW_W-1:0] == '0)
        |=> cur.load_low_current == LOW_W'(CODE_MIN)) else $error("low code zero stored");

    AST_LOW_WRITE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (reg_req.wr && reg_req.addr == ADDR_LOW && reg_req.wdata[LOW_W-1:0] != '0)
        |=> cur.load_low_current == $past(reg_req.wdata[LOW_W-1:0])) else $error("low code write lost");

    AST_HIGH_MIN: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_code_write(ADDR_HIGH) |=> cur.load_high_current == CODE_MIN) else $error("high code zero stored");

    // Reserved bits, enables and reset values
    AST_CTRL_RESERVED: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (reg_req.rd && reg_req.addr == ADDR_CTRL) |=> reg_rdata[DATA_W-1:1] == '0) else $error("reserved bits set");

    AST_EN_WRITE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (reg_req.wr && reg_req.addr == ADDR_EN)
        |=> (cur.ch1_load_enable == $past(reg_req.wdata[EN1_BIT])
        && cur.ch2_load_enable == $past(reg_req.wdata[EN2_BIT]))) else $error("enable write lost");

    AST_RESET_VALUES: assert property (@(posedge ref_clk)
        $rose(arst_n) |-> (!cur.load_idle_mode && cur.load_low_current == LOW_RST
        && cur.rising_threshold == THR_RST)) else $error("reset values wrong");
endmodule : load_current_ctrl_regs
`default_nettype wire

// ### load_regs_pkg.sv
// Shared constants and types for the load current control register bank
`default_nettype none
package load_regs_pkg;
    // Register port geometry
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int SAMPLE_W = 8;
    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_RAW = 10'h00E;
    localparam logic [ADDR_W-1:0] ADDR_DEC = 10'h00F;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 10'h010;
    localparam logic [ADDR_W-1:0] ADDR_THR = 10'h011;
    localparam logic [ADDR_W-1:0] ADDR_LOW = 10'h012;
    localparam logic [ADDR_W-1:0] ADDR_HIGH = 10'h013;
    localparam logic [ADDR_W-1:0] ADDR_EN = 10'h200;
    // Field positions
    localparam int IDLE_MODE_BIT = 0;
    localparam int EN1_BIT = 14;
    localparam int EN2_BIT = 15;
    localparam int LOW_W = 6;
    // Values after reset
    localparam logic IDLE_MODE_RST = 1'h0;
    localparam logic [7:0] THR_RST = 8'h1E;
    localparam logic [LOW_W-1:0] LOW_RST = 6'h1E;
    localparam logic [7:0] HIGH_RST = 8'hC8;
    // Clamp limits
    localparam logic [7:0] THR_MIN = 8'h01;
    localparam logic [7:0] THR_MAX = 8'hFE;
    localparam logic [7:0] CODE_MIN = 8'h01;
    // Converter pacing: 10 MHz clock, 100 kHz sample rate
    localparam int CLK_HZ = 10_000_000;
    localparam int SAMPLE_RATE_HZ = 100_000;
    localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE_HZ;
    localparam int TICK_W = $clog2(SAMPLE_CYCLES);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_CYCLES - 1);
    // Host request toward the register bank
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;
    // Drive toward one current sink
    typedef struct packed {
        logic high_sel;
        logic [7:0] code;
    } sink_out_t;
    // Sink states, Gray coded off -> low -> high
    typedef enum logic [1:0] {
        SINK_OFF = 2'b00,
        SINK_LOW = 2'b01,
        SINK_HIGH = 2'b11
    } sink_state_t;
    // Raise a code of zero to the smallest legal code
    function automatic logic [7:0] at_least_one(input logic [7:0] v);
        at_least_one = (v == 8'h00) ? CODE_MIN : v;
    endfunction : at_least_one
endpackage : load_regs_pkg
`default_nettype wire

// ### sample_decimator.sv
// Keeps one converter sample out of every 2^rate_sel for one channel
`timescale 1ns/10ps
`default_nettype none
module sample_decimator #(
    parameter int DW = 8,
    parameter int RATE_W = 2
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic sample_tick,
    input wire logic [DW-1:0] sample,
    input wire logic [RATE_W-1:0] rate_sel,
    output logic [DW-1:0] decimated
);
    import load_regs_pkg::*;
    // Whole state of the decimator
    typedef struct packed {
        logic [7:0] cnt;
        logic [DW-1:0] held;
    } dec_state_t;
    dec_state_t cur, next_cur;
    logic [7:0] last_cnt; // Final count of one decimation window
    // Window length follows the rate setting
    always_comb begin
        last_cnt = 8'((16'h0001 << rate_sel) - 16'h0001);
        next_cur = cur;
        if (sample_tick) begin
            if (cur.cnt >= last_cnt) begin
                next_cur.cnt = 8'h00;
                next_cur.held = sample;
            end else begin
                next_cur.cnt = cur.cnt + 8'h01;
            end
        end
    end
    // State register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end
    assign decimated = cur.held;
    // Decimated value only moves on a sample
    AST_DEC_ONLY_ON_TICK: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !sample_tick |=> $stable(decimated)) else $error("decimated sample moved without a sample");
endmodule : sample_decimator
`default_nettype wire

// ### sink_code_select.sv
// Picks off, low or high sink current for one channel from its sample
`timescale 1ns/10ps
`default_nettype none
module sink_code_select (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic idle_mode,
    input wire logic [7:0] sample,
    input wire logic [7:0] rising_threshold,
    input wire logic [5:0] low_code,
    input wire logic [7:0] high_code,
    output load_regs_pkg::sink_out_t sink
);
    import load_regs_pkg::*;
    // Whole state: current sink level and the registered drive
    typedef struct packed {
        sink_state_t level;
        sink_out_t drive;
    } sel_state_t;
    sel_state_t cur, next_cur;
    // Level choice; in low idle mode a sample equal to the threshold keeps the level, or goes low from off, a gentle hysteresis
    always_comb begin
        next_cur = cur;
        if (!enable || sample == 8'h00) begin
            next_cur.level = SINK_OFF;
        end else if (idle_mode) begin
            next_cur.level = SINK_HIGH;
        end else if (sample > rising_threshold) begin
            next_cur.level = SINK_HIGH;
        end else if (sample < rising_threshold) begin
            next_cur.level = SINK_LOW;
        end else if (cur.level == SINK_OFF) begin
            next_cur.level = SINK_LOW;
        end
        case (next_cur.level)
            SINK_LOW: begin
                next_cur.drive = '{high_sel: 1'b0, code: {2'b00, low_code}};
            end
            SINK_HIGH: begin
                next_cur.drive = '{high_sel: 1'b1, code: high_code};
            end
            default: begin
                next_cur.drive = '0;
            end
        endcase
    end
    // State register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end
    assign sink = cur.drive;
    AST_LOW_BAND: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (enable && !idle_mode && sample != 8'h00 && sample < rising_threshold)
        |=> (!sink.high_sel && sink.code == {2'b00, $past(low_code)})) else $error("low band not at low code");
    AST_RISE_HIGH: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (enable && !idle_mode && sample > rising_threshold)
        |=> (sink.high_sel && sink.code == $past(high_code))) else $error("above threshold not at high code");
    AST_HIGH_IDLE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (enable && idle_mode && sample != 8'h00)
        |=> (sink.high_sel && sink.code == $past(high_code))) else $error("high idle not at high code");
    AST_DISABLED_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !enable |=> (sink.code == 8'h00 && !sink.high_sel)) else $error("disabled sink draws current");
endmodule : sink_code_select
`default_nettype wire

// ### test_load_current_ctrl_regs.sv
// Self-checking bench for the load current control register bank
`timescale 1ns/10ps
`default_nettype none
module test_load_current_ctrl_regs;
    import load_regs_pkg::*;
    logic ref_clk = 1'b0; // 10 MHz system clock
    logic arst_n = 1'b0; // Power-on reset, low at start
    reg_req_t reg_req = '0; // Host strobes, idle
    logic [DATA_W-1:0] reg_rdata;
    logic [SAMPLE_W-1:0] adc_sample;
    logic adc_chan_sel;
    logic sample_tick;
    logic [1:0] decimation_rate_sel = 2'h0; // Keep every sample
    sink_out_t ch1_sink_pin;
    sink_out_t ch2_sink_pin;
    logic [7:0] ch1_level = 8'h00; // Analog levels seen by the converter model
    logic [7:0] ch2_level = 8'h00;
    int failures = 0;
    int checks = 0;
    int cycles = 0;

    always #50 ref_clk = ~ref_clk;

    load_current_ctrl_regs #(.RATE_W(2)) u_load_current_ctrl_regs (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .adc_sample(adc_sample),
        .adc_chan_sel(adc_chan_sel),
        .sample_tick(sample_tick),
        .decimation_rate_sel(decimation_rate_sel),
        .ch1_sink_pin(ch1_sink_pin),
        .ch2_sink_pin(ch2_sink_pin)
    );

    adc_source u_adc_source (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .sample_tick(sample_tick),
        .adc_chan_sel(adc_chan_sel),
        .ch1_level(ch1_level),
        .ch2_level(ch2_level),
        .adc_sample(adc_sample)
    );

    // Compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // One write strobe, launched just after an edge and dropped after the taking edge
    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        #10;
        reg_req.wr = 1'b1;
        reg_req.addr = a;
        reg_req.wdata = d;
        @(posedge ref_clk);
        #10;
        reg_req.wr = 1'b0;
    endtask : reg_write

    // One read strobe; data is registered so it is settled just after the taking edge
    task automatic expect_reg(input string what, input logic [ADDR_W-1:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        #10;
        reg_req.rd = 1'b1;
        reg_req.addr = a;
        @(posedge ref_clk);
        #10;
        reg_req.rd = 1'b0;
        check(what, reg_rdata, exp);
    endtask : expect_reg

    // Wait for the next conversion tick; returns cycles waited, bounded
    task automatic wait_tick(output int gap);
        gap = 0;
        do begin
            @(negedge ref_clk);
            gap++;
        end while (sample_tick !== 1'b1 && gap < 300);
    endtask : wait_tick

    // Expected sink drive from enable, mode, sample and codes
    function automatic sink_out_t exp_sink(input logic en, input logic mode, input logic [7:0] s,
                                           input logic [7:0] thr, input logic [5:0] low,
                                           input logic [7:0] high);
        if (!en || s == 8'h00) begin
            return '0;
        end
        if (mode || s > thr) begin
            return '{high_sel: 1'b1, code: high};
        end
        return '{high_sel: 1'b0, code: {2'h0, low}};
    endfunction : exp_sink

    // Keep a random sample off the threshold, where the level is history dependent
    function automatic logic [7:0] off_thr(input logic [7:0] s, input logic [7:0] thr);
        return (s == thr) ? (s ^ 8'h01) : s;
    endfunction : off_thr

    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end

    initial begin
        logic [7:0] thr;
        logic [7:0] s1;
        logic [7:0] s2;
        logic mode;
        logic [15:0] en;
        int gap;
        logic last_chan;
        void'($urandom(83));
        repeat (20) @(posedge ref_clk);
        #10;
        arst_n = 1'b1;
        // Values after reset, before the first tick lands
        expect_reg("raw", ADDR_RAW, 16'h0000);
        expect_reg("dec", ADDR_DEC, 16'h0000);
        expect_reg("ctrl", ADDR_CTRL, 16'h0000);
        expect_reg("thr", ADDR_THR, 16'h001E);
        expect_reg("low", ADDR_LOW, 16'h001E);
        expect_reg("high", ADDR_HIGH, 16'h00C8);
        expect_reg("en", ADDR_EN, 16'h0000);
        expect_reg("unmapped", 10'h0FF, 16'h0000);
        // Clamping at both ends, reserved bits dropped
        reg_write(ADDR_THR, 16'hFF00);
        expect_reg("thr lo", ADDR_THR, 16'h0001);
        reg_write(ADDR_THR, 16'h00FF);
        expect_reg("thr hi", ADDR_THR, 16'h00FE);
        thr = 8'($urandom_range(8'hFD, 8'h02));
        reg_write(ADDR_THR, {8'hAB, thr});
        expect_reg("thr mid", ADDR_THR, {8'h00, thr});
        reg_write(ADDR_LOW, 16'hFFC0);
        expect_reg("low zero", ADDR_LOW, 16'h0001);
        reg_write(ADDR_LOW, 16'h00FF);
        expect_reg("low max", ADDR_LOW, 16'h003F);
        reg_write(ADDR_HIGH, 16'hFF00);
        expect_reg("high zero", ADDR_HIGH, 16'h0001);
        reg_write(ADDR_CTRL, 16'hFFFF);
        expect_reg("ctrl rsvd", ADDR_CTRL, 16'h0001);
        reg_write(ADDR_EN, 16'hFFFF);
        expect_reg("en rsvd", ADDR_EN, 16'hC000);
        reg_write(ADDR_RAW, 16'hFFFF);
        reg_write(ADDR_DEC, 16'hFFFF);
        expect_reg("raw ro", ADDR_RAW, 16'h0000);
        expect_reg("dec ro", ADDR_DEC, 16'h0000);
        reg_write(ADDR_LOW, 16'h0005);
        reg_write(ADDR_HIGH, 16'h0040);
        last_chan = 1'b1;
        // Corner cases first, then random samples and modes; channel 2 disabled at i == 3
        for (int i = 0; i < 12; i++) begin
            mode = (i < 3) ? 1'b0 : 1'($urandom_range(1, 0));
            en = (i == 3) ? 16'h4000 : 16'hC000;
            case (i)
                0: begin
                    s1 = 8'h00;
                    s2 = thr + 8'h01;
                end
                1: begin
                    s1 = thr - 8'h01;
                    s2 = 8'hFF;
                end
                2: begin
                    s1 = 8'h01;
                    s2 = 8'h00;
                end
                default: begin
                    s1 = off_thr(8'($urandom), thr);
                    s2 = off_thr(8'($urandom), thr);
                end
            endcase
            reg_write(ADDR_CTRL, {15'h0000, mode});
            reg_write(ADDR_EN, en);
            ch1_level = s1;
            ch2_level = s2;
            // Two ticks store both channels; the second gap is a whole sample period
            for (int k = 0; k < 2; k++) begin
                wait_tick(gap);
                if (k == 1) check("tick gap", 16'(gap), 16'h0064);
                check("chan", {15'h0000, adc_chan_sel}, {15'h0000, ~last_chan});
                last_chan = adc_chan_sel;
            end
            repeat (3) @(posedge ref_clk);
            #10;
            check("sink1", {7'h00, ch1_sink_pin}, {7'h00, exp_sink(en[14], mode, s1, thr, 6'h05, 8'h40)});
            check("sink2", {7'h00, ch2_sink_pin}, {7'h00, exp_sink(en[15], mode, s2, thr, 6'h05, 8'h40)});
            expect_reg("raw pair", ADDR_RAW, {s2, s1});
            expect_reg("dec pair", ADDR_DEC, {s2, s1});
        end
        // Rate 1 keeps every second sample per channel; window counters sit at zero here
        decimation_rate_sel = 2'h1;
        for (int j = 0; j < 2; j++) begin
            ch1_level = 8'($urandom);
            ch2_level = 8'($urandom);
            repeat (2) wait_tick(gap);
            repeat (2) @(posedge ref_clk);
            #10;
            expect_reg("raw rate1", ADDR_RAW, {ch2_level, ch1_level});
            expect_reg("dec rate1", ADDR_DEC, (j == 0) ? {s2, s1} : {ch2_level, ch1_level});
        end
        conclude();
    end
endmodule : test_load_current_ctrl_regs
`default_nettype wire
